// ---- src/rhpm_pin_mux.sv ----
/*
  Pin function mux and section power/reset gating for a combo radio chip.
  Holds the Wishbone register file and the pin synchronisers.
  Assumes the radio, audio and WLAN cores run on clk; pins are asynchronous.
*/
`timescale 1ns/1ns
module rhpm_pin_mux (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire rhpm_pkg::rhpm_addr_type  wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire rhpm_pkg::rhpm_word_type  wb_dat_i,
  output rhpm_pkg::rhpm_word_type       wb_dat_o,
  output logic                         wb_ack_o,
  // Host control UART pins
  input  wire logic                    hci_uart_clear_to_send_n_i,
  output logic                         hci_uart_clear_to_send_n_o,
  output logic                         hci_uart_clear_to_send_n_oe_n,
  input  wire logic                    hci_uart_request_to_send_n_i,
  output logic                         hci_uart_request_to_send_n_o,
  output logic                         hci_uart_request_to_send_n_oe_n,
  input  wire logic                    hci_uart_serial_in,
  output logic                         hci_uart_serial_out,
  // Wake pins
  input  wire logic                    radio_host_alert_pin_i,
  output logic                         radio_host_alert_pin_o,
  output logic                         radio_host_alert_pin_oe_n,
  input  wire logic                    radio_device_alert_pin,
  // Dedicated audio pins
  input  wire logic                    audio_bit_clock_pin_i,
  output logic                         audio_bit_clock_pin_o,
  output logic                         audio_bit_clock_pin_oe_n,
  input  wire logic                    audio_frame_select_pin_i,
  output logic                         audio_frame_select_pin_o,
  output logic                         audio_frame_select_pin_oe_n,
  output logic                         audio_serial_out_pin,
  input  wire logic                    audio_serial_in_pin,
  // Power enables and pulls
  input  wire logic                    wlan_section_power_enable,
  input  wire logic                    radio_fm_section_power_enable,
  output logic                         wlanPullDownEn,
  output logic                         radioPullDownEn,
  // General-purpose pins
  input  wire rhpm_pkg::rhpm_gpio_type  gpioPinIn,
  output rhpm_pkg::rhpm_gpio_type       gpioPinOut,
  output rhpm_pkg::rhpm_gpio_type       gpioPinOeN,
  // Radio core side
  input  wire logic                    radioUartTxd,
  input  wire logic                    radioRxReady,
  input  wire logic                    radioHostAlert,
  output logic                         radioUartRxd,
  output logic                         radioTxPermit,
  output logic                         radioThreeWire,
  output logic                         radioDevAlert,
  // Audio core side
  input  wire logic                    audioClkOut,
  input  wire logic                    audioFrameOut,
  input  wire logic                    audioDataOut,
  output logic                         audioClkIn,
  output logic                         audioFrameIn,
  output logic                         audioDataIn,
  // WLAN core side, plus WLAN and radio section regulator and reset controls
  input  wire logic                    wlanHostAlert,
  output logic                         wlanRegulatorOn,
  output logic                         wlanSectionRstN,
  output logic                         radioRegulatorOn,
  output logic                         radioSectionRstN
);
  import rhpm_pkg::*;

  logic [1:0]       rstPipe_q;
  logic             rstN;
  logic [SYN_W-1:0] syn;
  rhpm_cfg_if       cfg ();

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe_q <= 2'h0;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end
  assign rstN = rstPipe_q[1];

  rhpm_wb_regs uRegs (
    .clk      (clk),
    .rstN     (rstN),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg      (cfg.regs)
  );

  // Clear-to-send and serial in enter inverted, so the cleared pipeline after reset
  // reads as line idle and host holding off: no false start bit, no early transmit
  wire [SYN_W-1:0] rawPins = {gpioPinIn, radio_fm_section_power_enable, wlan_section_power_enable,
                              audio_serial_in_pin, audio_frame_select_pin_i, audio_bit_clock_pin_i,
                              !hci_uart_serial_in, radio_device_alert_pin, radio_host_alert_pin_i,
                              hci_uart_request_to_send_n_i, !hci_uart_clear_to_send_n_i};

  rhpm_pin_sync #(.WIDTH(SYN_W)) uSync (
    .clk   (clk),
    .rstN  (rstN),
    .pinIn (rawPins),
    .level (syn)
  );

  assign cfg.gpioIn  = syn[SYN_GPIO_LSB +: 5];
  assign cfg.wlanEn  = syn[SYN_WLAN];
  assign cfg.radioEn = syn[SYN_RADIO];

  // Next values of every pin; all registered together below so a routing
  // change lands on one edge and untouched outputs keep their source
  wire pcm        = cfg.pcmRoute;
  wire rtsDrive   = !pcm | cfg.clkMaster;
  wire rtsVal     = pcm ? audioClkOut : !radioRxReady;
  wire hostDrive  = !pcm | cfg.frameMaster;
  wire hostVal    = pcm ? audioFrameOut : radioHostAlert;
  wire clkDrive   = !pcm & cfg.clkMaster;
  wire frmDrive   = !pcm & cfg.frameMaster;
  wire clkInVal   = pcm ? syn[SYN_RTS] : syn[SYN_ACLK];
  wire frmInVal   = pcm ? syn[SYN_HOST] : syn[SYN_AFRM];
  wire dataInVal  = pcm ? syn[SYN_DEV] : syn[SYN_ADIN];
  // Flow control is ignored once its pins carry audio
  wire txPermit   = pcm | syn[SYN_CTS];
  wire devAlert   = !pcm & syn[SYN_DEV];
  wire rhpm_gpio_type gpioDrive = cfg.gpioDir | {4'h0, cfg.gpio0Alert};
  wire rhpm_gpio_type gpioVal   = {cfg.gpioOut[4:1], cfg.gpio0Alert ? wlanHostAlert : cfg.gpioOut[0]};

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hci_uart_clear_to_send_n_o      <= 1'b1;
      hci_uart_clear_to_send_n_oe_n   <= 1'b1;
      hci_uart_request_to_send_n_o    <= 1'b1;
      hci_uart_request_to_send_n_oe_n <= 1'b0;
      hci_uart_serial_out             <= 1'b1;
      radio_host_alert_pin_o          <= 1'b0;
      radio_host_alert_pin_oe_n       <= 1'b0;
      audio_bit_clock_pin_o           <= 1'b0;
      audio_bit_clock_pin_oe_n        <= 1'b1;
      audio_frame_select_pin_o        <= 1'b0;
      audio_frame_select_pin_oe_n     <= 1'b1;
      audio_serial_out_pin            <= 1'b0;
    end else begin
      hci_uart_clear_to_send_n_o      <= pcm ? audioDataOut : 1'b1;
      hci_uart_clear_to_send_n_oe_n   <= rhpm_oe_n(pcm);
      hci_uart_request_to_send_n_o    <= rtsVal;
      hci_uart_request_to_send_n_oe_n <= rhpm_oe_n(rtsDrive);
      hci_uart_serial_out             <= radioUartTxd;
      radio_host_alert_pin_o          <= hostVal;
      radio_host_alert_pin_oe_n       <= rhpm_oe_n(hostDrive);
      audio_bit_clock_pin_o           <= audioClkOut;
      audio_bit_clock_pin_oe_n        <= rhpm_oe_n(clkDrive);
      audio_frame_select_pin_o        <= audioFrameOut;
      audio_frame_select_pin_oe_n     <= rhpm_oe_n(frmDrive);
      audio_serial_out_pin            <= pcm ? 1'b0 : audioDataOut;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      radioUartRxd   <= 1'b1;
      radioTxPermit  <= 1'b0;
      radioThreeWire <= 1'b0;
      radioDevAlert  <= 1'b0;
      audioClkIn     <= 1'b0;
      audioFrameIn   <= 1'b0;
      audioDataIn    <= 1'b0;
    end else begin
      radioUartRxd   <= !syn[SYN_RXD];
      radioTxPermit  <= txPermit;
      radioThreeWire <= pcm;
      radioDevAlert  <= devAlert;
      audioClkIn     <= clkInVal;
      audioFrameIn   <= frmInVal;
      audioDataIn    <= dataInVal;
    end
  end

  // Sections stay powered down and in reset until their enable is seen high
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wlanRegulatorOn  <= 1'b0;
      wlanSectionRstN  <= 1'b0;
      radioRegulatorOn <= 1'b0;
      radioSectionRstN <= 1'b0;
      wlanPullDownEn   <= 1'b1;
      radioPullDownEn  <= 1'b1;
      gpioPinOut       <= GPIO_OUT_RESET;
      gpioPinOeN       <= 5'h1F;
    end else begin
      wlanRegulatorOn  <= syn[SYN_WLAN];
      wlanSectionRstN  <= syn[SYN_WLAN];
      radioRegulatorOn <= syn[SYN_RADIO];
      radioSectionRstN <= syn[SYN_RADIO];
      wlanPullDownEn   <= !cfg.wlanPullOff;
      radioPullDownEn  <= !cfg.radioPullOff;
      gpioPinOut       <= gpioVal;
      gpioPinOeN       <= ~gpioDrive;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstN);

  // Synchronised clear-to-send is stored inverted: high means the host allows sending
  a_cts_permit: assert property (!pcm && syn[SYN_CTS] |=> radioTxPermit)
    else $error("transmit not permitted while clear-to-send low");
  a_cts_block: assert property (!pcm && !syn[SYN_CTS] |=> !radioTxPermit && !radioThreeWire)
    else $error("transmit permitted while clear-to-send high");
  a_rts_drive: assert property (!pcm |=> !hci_uart_request_to_send_n_oe_n &&
                                hci_uart_request_to_send_n_o == !$past(radioRxReady))
    else $error("request-to-send not the inverse of receive ready");
  a_wake_default: assert property (!pcm |=> !radio_host_alert_pin_oe_n &&
                                   radio_host_alert_pin_o == $past(radioHostAlert) &&
                                   radioDevAlert == $past(syn[SYN_DEV]))
    else $error("wake pins not in default function");
  a_uart_default: assert property (!pcm |=> hci_uart_clear_to_send_n_oe_n)
    else $error("clear-to-send pin driven in UART mode");
  a_pcm_route: assert property (pcm |=> !hci_uart_clear_to_send_n_oe_n &&
                                hci_uart_clear_to_send_n_o == $past(audioDataOut) &&
                                audioDataIn == $past(syn[SYN_DEV]) && audioFrameIn == $past(syn[SYN_HOST]))
    else $error("audio not routed onto UART and wake pins");
  a_pcm_clk: assert property (pcm && cfg.clkMaster |=> hci_uart_request_to_send_n_o == $past(audioClkOut))
    else $error("bit clock not on request-to-send pin");
  a_three_wire: assert property (pcm |=> radioTxPermit && radioThreeWire && !radioDevAlert)
    else $error("three-wire transport not in force");
  a_clk_master: assert property (!pcm |=> audio_bit_clock_pin_oe_n == !$past(cfg.clkMaster))
    else $error("bit clock direction wrong");
  a_frame_master: assert property (!pcm |=> audio_frame_select_pin_oe_n == !$past(cfg.frameMaster))
    else $error("frame select direction wrong");
  a_wlan_power: assert property (wlan_section_power_enable [*5] |-> ##[1:2] wlanRegulatorOn)
    else $error("WLAN regulators not on after enable");
  a_wlan_reset: assert property (!syn[SYN_WLAN] |=> !wlanSectionRstN && !wlanRegulatorOn)
    else $error("WLAN section not held in reset");
  a_radio_power: assert property (radio_fm_section_power_enable [*5] |-> ##[1:2] radioRegulatorOn)
    else $error("radio regulators not on after enable");
  a_radio_reset: assert property (!syn[SYN_RADIO] |=> !radioSectionRstN && !radioRegulatorOn)
    else $error("radio section not held in reset");
  a_pull_follow: assert property ($rose(rstN) |-> wlanPullDownEn && radioPullDownEn ##1
                                  wlanPullDownEn == !$past(cfg.wlanPullOff))
    else $error("pull-down enable wrong");
  a_gpio0_alert: assert property (cfg.gpio0Alert |=> !gpioPinOeN[0] && gpioPinOut[0] == $past(wlanHostAlert))
    else $error("GPIO 0 not driving host alert");
  a_route_glitch: assert property ($changed(pcm) && $stable(radioUartTxd) |=> $stable(hci_uart_serial_out))
    else $error("serial out disturbed by routing change");
  a_gpio_dir: assert property (1'b1 |=> gpioPinOeN[4:1] == ~$past(cfg.gpioDir[4:1]) &&
                               gpioPinOut[4:1] == $past(cfg.gpioOut[4:1]))
    else $error("GPIO 1-4 not following direction and value");
  a_cts_idle: assert property ($rose(rstN) |=> (!radioTxPermit && radioUartRxd) [*3])
    else $error("transmit permitted or serial line low straight after reset");
  a_rxd_follow: assert property (1'b1 |=> radioUartRxd == !$past(syn[SYN_RXD]))
    else $error("serial input not passed to the radio core");
  a_pcm_frame: assert property (pcm && cfg.frameMaster |=> !radio_host_alert_pin_oe_n &&
                                radio_host_alert_pin_o == $past(audioFrameOut))
    else $error("frame sync not on host alert pin");
  a_audio_data: assert property (1'b1 |=> audio_serial_out_pin == (!$past(pcm) && $past(audioDataOut)))
    else $error("dedicated audio data pin not released under routing");
  a_audio_in_default: assert property (!pcm |=> audioClkIn == $past(syn[SYN_ACLK]) &&
                                       audioFrameIn == $past(syn[SYN_AFRM]) && audioDataIn == $past(syn[SYN_ADIN]))
    else $error("audio inputs not taken from dedicated pins");
  a_radio_pull: assert property (1'b1 |=> radioPullDownEn == !$past(cfg.radioPullOff))
    else $error("radio pull-down enable wrong");
  a_gpio0_plain: assert property (!cfg.gpio0Alert |=> gpioPinOeN[0] == !$past(cfg.gpioDir[0]) &&
                                  gpioPinOut[0] == $past(cfg.gpioOut[0]))
    else $error("GPIO 0 not following its register");

  c_pcm_route: cover property ($rose(pcm) ##1 !hci_uart_clear_to_send_n_oe_n);
  c_clk_master: cover property (cfg.clkMaster && !pcm ##1 !audio_bit_clock_pin_oe_n);
  c_gpio0_alert: cover property (cfg.gpio0Alert ##1 gpioPinOut[0]);
  c_wlan_up: cover property ($rose(wlanSectionRstN));
  c_pcm_slave: cover property (pcm && !cfg.clkMaster ##1 audioClkIn);

endmodule : rhpm_pin_mux

// ---- include/rhpm_pkg.sv ----
/*
  Shared constants for the radio host pin mux: register offsets, field
  positions, reset values and the bit layout of the synchronised pin vector.
  Assumes a 32-bit classic Wishbone register bus decoded on 8 address bits.
*/
package rhpm_pkg;

  typedef logic [4:0]  rhpm_gpio_type;
  typedef logic [7:0]  rhpm_addr_type;
  typedef logic [31:0] rhpm_word_type;

  // Register byte offsets
  localparam rhpm_addr_type OFS_CTRL     = 8'h00;
  localparam rhpm_addr_type OFS_GPIO_DIR = 8'h04;
  localparam rhpm_addr_type OFS_GPIO_OUT = 8'h08;
  localparam rhpm_addr_type OFS_STATUS   = 8'h0C;

  // Control register fields
  localparam int CTRL_PCM_ROUTE    = 0;
  localparam int CTRL_CLK_MASTER   = 1;
  localparam int CTRL_FRAME_MASTER = 2;
  localparam int CTRL_WLAN_PULL    = 3;
  localparam int CTRL_RADIO_PULL   = 4;
  localparam int CTRL_GPIO0_ALERT  = 5;
  localparam int CTRL_W            = 6;

  // Reset values; a zero pull bit keeps the pull-down on
  localparam logic [5:0]    CTRL_RESET     = 6'h00;
  localparam rhpm_gpio_type GPIO_DIR_RESET = 5'h00;
  localparam rhpm_gpio_type GPIO_OUT_RESET = 5'h00;

  // Status register fields
  localparam int STAT_GPIO_LSB = 0;
  localparam int STAT_WLAN_EN  = 5;
  localparam int STAT_RADIO_EN = 6;

  // Positions in the synchronised pin vector
  localparam int SYN_CTS      = 0;
  localparam int SYN_RTS      = 1;
  localparam int SYN_HOST     = 2;
  localparam int SYN_DEV      = 3;
  localparam int SYN_RXD      = 4;
  localparam int SYN_ACLK     = 5;
  localparam int SYN_AFRM     = 6;
  localparam int SYN_ADIN     = 7;
  localparam int SYN_WLAN     = 8;
  localparam int SYN_RADIO    = 9;
  localparam int SYN_GPIO_LSB = 10;
  localparam int SYN_W        = 15;

  // Output enables are active low: low while the pin is driven
  function automatic logic rhpm_oe_n(input logic drive);
    return !drive;
  endfunction : rhpm_oe_n

endpackage : rhpm_pkg

// ---- include/rhpm_cfg_if.sv ----
/*
  Configuration and status bundle between the register file and the pin mux.
  Assumes both ends run on the same clock and reset.
*/
`timescale 1ns/1ns
interface rhpm_cfg_if;
  import rhpm_pkg::*;
  logic          pcmRoute;
  logic          clkMaster;
  logic          frameMaster;
  logic          wlanPullOff;
  logic          radioPullOff;
  logic          gpio0Alert;
  rhpm_gpio_type gpioDir;
  rhpm_gpio_type gpioOut;
  rhpm_gpio_type gpioIn;
  logic          wlanEn;
  logic          radioEn;

  modport regs (output pcmRoute, clkMaster, frameMaster, wlanPullOff, radioPullOff,
                output gpio0Alert, gpioDir, gpioOut,
                input  gpioIn, wlanEn, radioEn);
  modport core (input  pcmRoute, clkMaster, frameMaster, wlanPullOff, radioPullOff,
                input  gpio0Alert, gpioDir, gpioOut,
                output gpioIn, wlanEn, radioEn);
endinterface : rhpm_cfg_if

// ---- src/rhpm_pin_sync.sv ----
/*
  Three-stage synchroniser for pins from outside the clock domain.
  A new level is taken only once the second and third stages agree.
  Assumes rstN is already synchronous to clk on release.
*/
`timescale 1ns/1ns
module rhpm_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Raw pins and filtered levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level
);

  for (genvar i = 0; i < WIDTH; i++) begin : gBit
    logic [2:0] stg_q;
    logic       lvl_q;
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        stg_q <= 3'h0;
        lvl_q <= 1'b0;
      end else begin
        stg_q <= {stg_q[1:0], pinIn[i]};
        // Stage 0 is never looked at here, only shifted on
        if (stg_q[1] == stg_q[2]) begin
          lvl_q <= stg_q[2];
        end
      end
    end
    assign level[i] = lvl_q;
  end

endmodule : rhpm_pin_sync

// ---- src/rhpm_wb_regs.sv ----
/*
  Classic Wishbone slave holding the pin mux configuration.
  Assumes a single-cycle classic master; answers every address one cycle
  after the request, unmapped ones with zero data and no write effect.
*/
`timescale 1ns/1ns
module rhpm_wb_regs (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rstN,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire rhpm_pkg::rhpm_addr_type wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire rhpm_pkg::rhpm_word_type wb_dat_i,
  output rhpm_pkg::rhpm_word_type      wb_dat_o,
  output logic                        wb_ack_o,
  // Configuration towards the mux
  rhpm_cfg_if.regs                    cfg
);
  import rhpm_pkg::*;

  logic [CTRL_W-1:0] ctrl_q;
  rhpm_gpio_type     dir_q;
  rhpm_gpio_type     out_q;
  logic              ack_q;
  rhpm_word_type     rdat_q;

  // Ack drops after one cycle so a held request is not taken twice
  wire req     = wb_cyc_i & wb_stb_i & !ack_q;
  wire wrLow   = req & wb_we_i & wb_sel_i[0];
  wire selCtrl = wb_adr_i == OFS_CTRL;
  wire selDir  = wb_adr_i == OFS_GPIO_DIR;
  wire selOut  = wb_adr_i == OFS_GPIO_OUT;
  wire selStat = wb_adr_i == OFS_STATUS;
  wire [6:0] statBits = {cfg.radioEn, cfg.wlanEn, cfg.gpioIn};
  wire rhpm_word_type rdWord = selCtrl ? {26'h0000000, ctrl_q} :
                               selDir  ? {27'h0000000, dir_q} :
                               selOut  ? {27'h0000000, out_q} :
                               selStat ? {25'h0000000, statBits} : 32'h00000000;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
      ctrl_q <= CTRL_RESET;
      dir_q  <= GPIO_DIR_RESET;
      out_q  <= GPIO_OUT_RESET;
    end else begin
      ack_q <= req;
      if (req) begin
        rdat_q <= rdWord;
      end
      if (wrLow && selCtrl) begin
        ctrl_q <= wb_dat_i[CTRL_W-1:0];
      end
      if (wrLow && selDir) begin
        dir_q <= wb_dat_i[4:0];
      end
      if (wrLow && selOut) begin
        out_q <= wb_dat_i[4:0];
      end
    end
  end

  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdat_q;
  assign cfg.pcmRoute     = ctrl_q[CTRL_PCM_ROUTE];
  assign cfg.clkMaster    = ctrl_q[CTRL_CLK_MASTER];
  assign cfg.frameMaster  = ctrl_q[CTRL_FRAME_MASTER];
  assign cfg.wlanPullOff  = ctrl_q[CTRL_WLAN_PULL];
  assign cfg.radioPullOff = ctrl_q[CTRL_RADIO_PULL];
  assign cfg.gpio0Alert   = ctrl_q[CTRL_GPIO0_ALERT];
  assign cfg.gpioDir      = dir_q;
  assign cfg.gpioOut      = out_q;

endmodule : rhpm_wb_regs

// ---- verification/rhpm_host_model.sv ----
/* Host processor model: flow control, power enables and serial data line.
   Assumes device pin enables are low while the device drives the pin. */
`timescale 1ns/1ns
module rhpm_host_model (
  // Bench commands
  input  wire logic holdTx,
  input  wire logic wlanOn,
  input  wire logic radioOn,
  input  wire logic hostTxd,
  // Device side of the clear-to-send pin
  input  wire logic ctsO,
  input  wire logic ctsOeN,
  // Pins
  output logic      ctsWire,
  output logic      serialIn,
  output logic      wlanEnPin,
  output logic      radioEnPin
);
  // Host yields the line once PCM data owns it, so no contention
  assign ctsWire    = ctsOeN ? holdTx : ctsO;
  assign serialIn   = hostTxd;
  assign wlanEnPin  = wlanOn;
  assign radioEnPin = radioOn;
endmodule : rhpm_host_model

// ---- verification/rhpm_pin_mux_tb_top.sv ----
/* Bench for the pin mux: Wishbone tasks, pin scenarios, verdict.
   Assumes five-edge pin latency; the Wishbone task waits for ack. */
`timescale 1ns/1ns
module rhpm_pin_mux_tb_top;
  import rhpm_pkg::*;
  logic clk = 0, arstN = 0, cyc = 0, stb = 0, we = 0, ack;
  rhpm_addr_type adr = '0;
  rhpm_word_type dat = '0, datO, rdat;
  logic ctsO, ctsOeN, ctsWire, rtsO, rtsOeN, hostO, hostOeN, aclkO, aclkOeN, afrmO, afrmOeN, aOut, serIn, serOut;
  logic wlanPin, radioPin, wlanPd, radioPd, uRxd, txPermit, threeWire, devAlert, cIn, fIn, dIn;
  logic wReg, wRst, rReg, rRst;
  logic txd = 1, rxReady = 1, hAlert = 0, cOut = 0, fOut = 0, dOut = 0, wAlert = 0;
  logic holdTx = 1, wlanOn = 0, radioOn = 0, extClk = 0, devPin = 0, hostTxd = 1;
  rhpm_gpio_type gpIn = 5'h15, gpOut, gpOeN;
  int fail_count = 0, compares = 0;

  rhpm_host_model host (.holdTx(holdTx), .wlanOn(wlanOn), .radioOn(radioOn), .hostTxd(hostTxd), .ctsO(ctsO),
    .ctsOeN(ctsOeN),
    .ctsWire(ctsWire), .serialIn(serIn), .wlanEnPin(wlanPin), .radioEnPin(radioPin));

  rhpm_pin_mux uut (.clk(clk), .arst_n(arstN), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack),
    .hci_uart_clear_to_send_n_i(ctsWire), .hci_uart_clear_to_send_n_o(ctsO), .hci_uart_clear_to_send_n_oe_n(ctsOeN),
    .hci_uart_request_to_send_n_i(rtsOeN ? extClk : rtsO), .hci_uart_request_to_send_n_o(rtsO),
    .hci_uart_request_to_send_n_oe_n(rtsOeN), .hci_uart_serial_in(serIn), .hci_uart_serial_out(serOut),
    .radio_host_alert_pin_i(hostOeN ? !extClk : hostO), .radio_host_alert_pin_o(hostO),
    .radio_host_alert_pin_oe_n(hostOeN), .radio_device_alert_pin(devPin),
    .audio_bit_clock_pin_i(aclkOeN ? extClk : aclkO), .audio_bit_clock_pin_o(aclkO),
    .audio_bit_clock_pin_oe_n(aclkOeN), .audio_frame_select_pin_i(afrmOeN ? !extClk : afrmO),
    .audio_frame_select_pin_o(afrmO), .audio_frame_select_pin_oe_n(afrmOeN), .audio_serial_out_pin(aOut),
    .audio_serial_in_pin(devPin), .wlan_section_power_enable(wlanPin), .radio_fm_section_power_enable(radioPin),
    .wlanPullDownEn(wlanPd), .radioPullDownEn(radioPd), .gpioPinIn(gpIn), .gpioPinOut(gpOut), .gpioPinOeN(gpOeN),
    .radioUartTxd(txd), .radioRxReady(rxReady), .radioHostAlert(hAlert), .radioUartRxd(uRxd),
    .radioTxPermit(txPermit), .radioThreeWire(threeWire), .radioDevAlert(devAlert), .audioClkOut(cOut),
    .audioFrameOut(fOut), .audioDataOut(dOut), .audioClkIn(cIn), .audioFrameIn(fIn), .audioDataIn(dIn),
    .wlanHostAlert(wAlert), .wlanRegulatorOn(wReg), .wlanSectionRstN(wRst), .radioRegulatorOn(rReg),
    .radioSectionRstN(rRst));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input rhpm_addr_type a, input rhpm_word_type d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  // Pins take four edges through the synchroniser and one more at the output register; eight leaves margin
  task automatic settle;
    repeat (8) @(posedge clk);
  endtask : settle

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    repeat (12) @(posedge clk);
    arstN <= 1'b1;
    repeat (4) @(posedge clk);
    chk({wlanPd, radioPd, wReg, wRst, rReg, rRst, txPermit, uRxd}, 8'hC1);
    wb(1'b0, OFS_CTRL, '0);
    chk(rdat, 32'h0);
    hAlert <= 1'b1;
    devPin <= 1'b1;
    txd    <= 1'b0;
    hostTxd <= 1'b0;
    settle();
    chk({rtsO, rtsOeN, hostO, hostOeN, devAlert, threeWire, serOut, uRxd}, 8'h28);
    rxReady <= 1'b0;
    settle();
    chk(rtsO, 1'b1);
    for (int i = 1; i >= 0; i--) begin
      holdTx <= i[0];
      settle();
      chk(txPermit, !i[0]);
    end
    wlanOn <= 1'b1;
    settle();
    chk({wReg, wRst, rReg, rRst}, 4'hC);
    radioOn <= 1'b1;
    settle();
    chk({rReg, rRst}, 2'h3);
    wb(1'b0, OFS_STATUS, '0);
    chk(rdat, 32'h75);
    wlanOn <= 1'b0;
    settle();
    chk({wReg, wRst}, 2'h0);
    wb(1'b1, OFS_CTRL, 32'h18);
    settle();
    chk({wlanPd, radioPd}, 2'h0);
    wb(1'b1, OFS_GPIO_DIR, 32'h1E);
    wb(1'b1, OFS_GPIO_OUT, 32'h0A);
    wb(1'b1, 8'h10, 32'hFF);
    wb(1'b0, 8'h10, '0);
    chk(rdat, 32'h0);
    settle();
    chk({gpOeN, gpOut}, 10'h02A);
    wAlert <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h20);
    settle();
    chk({gpOeN, gpOut}, 10'h00B);
    cOut <= 1'b1;
    fOut <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h06);
    settle();
    chk({aclkOeN, aclkO, afrmOeN, afrmO}, 4'h5);
    extClk <= 1'b1;
    dOut   <= 1'b1;
    wb(1'b1, OFS_CTRL, 32'h01);
    settle();
    // Slave routing: clock from the request pin, frame from the host alert pin
    chk({ctsOeN, ctsO, rtsOeN, hostOeN, aclkOeN, afrmOeN, aOut, cIn, fIn, dIn}, 10'h1F5);
    chk({threeWire, txPermit, devAlert}, 3'h6);
    wb(1'b1, OFS_CTRL, 32'h07);
    settle();
    chk({rtsOeN, rtsO, hostOeN, hostO}, 4'h5);
    close_out();
  end
endmodule : rhpm_pin_mux_tb_top
